// file: rtl/test_wrapper_regs.sv
`timescale 1ns/1ps
module test_wrapper_regs #(
    parameter int NUM_CH = 8
) (
    input  wire logic                                    mclk,          // System clock
    input  wire logic                                    resetn,        // Block reset, active low
    input  wire logic                                    wrck,          // Test clock pin
    input  wire logic                                    wrst_n,        // Wrapper reset pin, active low
    input  wire logic                                    wsi,           // Serial input
    input  wire logic                                    select_wir,    // Instruction select
    input  wire logic                                    capture_wr,    // Capture strobe
    input  wire logic                                    shift_wr,      // Shift strobe
    input  wire logic                                    update_wr,     // Update strobe
    output logic [NUM_CH-1:0]                            wso,           // Per-channel serial out
    input  wire logic [NUM_CH*wrapper_pkg::LEN_SCAN-1:0]   scan_pin_in,   // Pin levels
    output logic [NUM_CH*wrapper_pkg::LEN_SCAN-1:0]        scan_pin_out,  // Scan drive values
    output logic [NUM_CH-1:0]                            scan_pin_oe,   // Scan drives pins
    output logic [NUM_CH-1:0]                            scan_pin_float,// Functional pins float
    output logic [NUM_CH-1:0]                            tx_all_high,   // Drive transmit IOs high
    input  wire logic [NUM_CH*wrapper_pkg::LEN_DSIG-1:0]   dsig_in,       // Data lane signatures
    output logic [NUM_CH*wrapper_pkg::LEN_DSIG-1:0]        dsig_seed,     // Seed values
    output logic [NUM_CH-1:0]                            dsig_seed_load,// Seed load pulse
    input  wire logic [NUM_CH*wrapper_pkg::LEN_CSIG-1:0]   csig_in,       // Command lane signatures
    output logic [NUM_CH*wrapper_pkg::LEN_MASK-1:0]        sig_mask,      // Signature bit mask
    output logic [NUM_CH*wrapper_pkg::LEN_SETUP-1:0]       csig_setup,    // Command signature setup
    input  wire logic [wrapper_pkg::LEN_TEMP-1:0]          temp_code,     // Temperature code
    input  wire logic [NUM_CH*wrapper_pkg::LEN_MODE-1:0]   mode_reg_in,   // Mode register image
    output logic [NUM_CH*wrapper_pkg::LEN_MODE-1:0]        mode_reg_out,  // Mode register write data
    output logic [NUM_CH-1:0]                            mode_reg_wr,   // Mode register write pulse
    input  wire logic [NUM_CH*wrapper_pkg::LEN_STICKY-1:0] sticky_in,     // Compare sticky errors
    output logic                                         func_reset,    // Functional reset pulse
    output logic                                         self_test_kill // Stop self-test engine
);

    localparam int SRW  = wrapper_pkg::SR_W;
    localparam int LSC  = wrapper_pkg::LEN_SCAN;
    localparam int LDS  = wrapper_pkg::LEN_DSIG;
    localparam int LCS  = wrapper_pkg::LEN_CSIG;
    localparam int LMK  = wrapper_pkg::LEN_MASK;
    localparam int LST  = wrapper_pkg::LEN_SETUP;
    localparam int LMD  = wrapper_pkg::LEN_MODE;
    localparam int LSK  = wrapper_pkg::LEN_STICKY;
    localparam int LTP  = wrapper_pkg::LEN_TEMP;

    initial begin
        if (NUM_CH < 1 || NUM_CH > wrapper_pkg::MAX_CH) begin
            $error("NUM_CH out of range");
        end
    end

    // ************************************************************
    // Pin synchronisers and test clock edges
    // ************************************************************
    logic [wrapper_pkg::SYNC_W-1:0] pin_raw;
    logic [wrapper_pkg::SYNC_W-1:0] meta_reg;
    logic [wrapper_pkg::SYNC_W-1:0] sync_reg;
    logic                           wrck_d_reg;
    logic                           rst_meta_reg;
    logic                           wrap_rst_n_reg;
    logic                           wrap_arst_n;

    assign pin_raw = {wrck, wsi, select_wir, capture_wr, shift_wr, update_wr};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg   <= '0;
            sync_reg   <= '0;
            wrck_d_reg <= 1'b0;
        end else begin
            meta_reg   <= pin_raw;
            sync_reg   <= meta_reg;
            wrck_d_reg <= sync_reg[5];
        end
    end

    // Assertion is immediate, release is clocked to avoid a runt reset
    assign wrap_arst_n = resetn & wrst_n;

    always_ff @(posedge mclk or negedge wrap_arst_n) begin
        if (!wrap_arst_n) begin
            rst_meta_reg   <= 1'b0;
            wrap_rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            wrap_rst_n_reg <= rst_meta_reg;
        end
    end

    wire wrck_s   = sync_reg[5];
    wire wsi_s    = sync_reg[4];
    wire sel_s    = sync_reg[3];
    wire cap_s    = sync_reg[2];
    wire shf_s    = sync_reg[1];
    wire upd_s    = sync_reg[0];
    wire wrck_ris = wrck_s & ~wrck_d_reg;
    wire wrck_fal = ~wrck_s & wrck_d_reg;

    wire ir_shift  = wrck_ris & sel_s & shf_s;
    wire ir_update = wrck_fal & sel_s & upd_s;
    wire dr_cap    = wrck_ris & ~sel_s & cap_s;
    wire dr_shift  = wrck_ris & ~sel_s & shf_s & ~cap_s;
    wire dr_update = wrck_fal & ~sel_s & upd_s;

    // ************************************************************
    // Instruction register
    // ************************************************************
    logic [wrapper_pkg::WIR_W-1:0] wir_sr_reg;
    logic [wrapper_pkg::WIR_W-1:0] wir_upd_reg;
    logic                          func_reset_reg;
    logic                          kill_reg;
    logic [7:0]                    new_op;
    logic [7:0]                    cur_op;
    logic [3:0]                    new_ch;
    logic [3:0]                    cur_ch;
    logic                          new_glob;
    logic                          cur_glob;

    always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
        if (!wrap_rst_n_reg) begin
            wir_sr_reg     <= wrapper_pkg::WIR_RESET;
            wir_upd_reg    <= wrapper_pkg::WIR_RESET;
            func_reset_reg <= 1'b0;
        end else begin
            // Capture is never acted on while the instruction is selected
            if (ir_shift) begin
                wir_sr_reg <= {wsi_s, wir_sr_reg[wrapper_pkg::WIR_W-1:1]};
            end
            if (ir_update) begin
                wir_upd_reg <= wir_sr_reg;
            end
            func_reset_reg <= ir_update & (new_op == wrapper_pkg::OP_FUNC_RESET);
        end
    end

    // Held high through wrapper reset, drops one cycle after release
    always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
        if (!wrap_rst_n_reg) begin
            kill_reg <= 1'b1;
        end else begin
            kill_reg <= 1'b0;
        end
    end

    assign func_reset     = func_reset_reg;
    assign self_test_kill = kill_reg;

    // ************************************************************
    // Channel and opcode decode
    // ************************************************************
    assign new_ch   = wir_sr_reg[wrapper_pkg::CH_MSB:wrapper_pkg::CH_LSB];
    assign cur_ch   = wir_upd_reg[wrapper_pkg::CH_MSB:wrapper_pkg::CH_LSB];
    assign new_op   = wrapper_pkg::op_known(wir_sr_reg[wrapper_pkg::OP_MSB:0]) ?
                      wir_sr_reg[wrapper_pkg::OP_MSB:0] : wrapper_pkg::OP_BYPASS;
    assign cur_op   = wrapper_pkg::op_known(wir_upd_reg[wrapper_pkg::OP_MSB:0]) ?
                      wir_upd_reg[wrapper_pkg::OP_MSB:0] : wrapper_pkg::OP_BYPASS;
    // Bypass, functional reset and temperature ignore the channel field
    assign new_glob = (new_op == wrapper_pkg::OP_BYPASS) | (new_op == wrapper_pkg::OP_FUNC_RESET) |
                      (new_op == wrapper_pkg::OP_TEMP);
    assign cur_glob = (cur_op == wrapper_pkg::OP_BYPASS) | (cur_op == wrapper_pkg::OP_FUNC_RESET) |
                      (cur_op == wrapper_pkg::OP_TEMP);

    // ************************************************************
    // Per-channel data registers
    // ************************************************************
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic [7:0]     op_reg;
            logic [SRW-1:0] sr_reg;
            logic [SRW-1:0] sr_next;
            logic [SRW-1:0] cap_val;
            logic [8:0]     len;
            logic [LSC-1:0] scan_reg;
            logic [LDS-1:0] seed_reg;
            logic [LMK-1:0] mask_reg;
            logic [LST-1:0] setup_reg;
            logic [LMD-1:0] mode_reg;
            logic           seed_ld_reg;
            logic           mode_wr_reg;
            logic           wso_reg;
            wire            sel_new;
            wire            sel_cur;
            wire            ch_cap;
            wire            ch_shift;
            wire            ch_upd;

            // Reserved codes match no channel and never equal Fh
            assign sel_new  = new_glob | (new_ch == wrapper_pkg::CH_ALL) | (new_ch == 4'(c));
            assign sel_cur  = cur_glob | (cur_ch == wrapper_pkg::CH_ALL) | (cur_ch == 4'(c));
            assign ch_cap   = dr_cap & sel_cur;
            assign ch_shift = dr_shift & sel_cur;
            assign ch_upd   = dr_update & sel_cur;
            assign len      = wrapper_pkg::op_len(op_reg);

            always_comb begin
                unique case (op_reg)
                    wrapper_pkg::OP_SCAN_RX:    cap_val = SRW'(scan_pin_in[c*LSC +: LSC]);
                    wrapper_pkg::OP_DATA_SIG:   cap_val = SRW'(dsig_in[c*LDS +: LDS]);
                    wrapper_pkg::OP_CMD_SIG:    cap_val = SRW'(csig_in[c*LCS +: LCS]);
                    wrapper_pkg::OP_TEMP:       cap_val = SRW'(temp_code);
                    wrapper_pkg::OP_MODE_REG:   cap_val = SRW'(mode_reg_in[c*LMD +: LMD]);
                    wrapper_pkg::OP_ERR_STICKY: cap_val = SRW'(sticky_in[c*LSK +: LSK]);
                    default:                    cap_val = sr_reg;
                endcase
            end

            // Shift right so bit 0 leaves first; input enters at bit len-1, the top of the selected length
            always_comb begin
                sr_next = sr_reg >> 1;
                sr_next[len - 9'd1] = wsi_s;
            end

            always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
                if (!wrap_rst_n_reg) begin
                    op_reg <= wrapper_pkg::OP_BYPASS;
                end else if (ir_update && sel_new) begin
                    op_reg <= new_op;
                end
            end

            always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
                if (!wrap_rst_n_reg) begin
                    sr_reg <= '0;
                end else if (ch_cap) begin
                    sr_reg <= cap_val;
                end else if (ch_shift) begin
                    sr_reg <= sr_next;
                end
            end

            // Whole update stages load in one cycle so outputs change together
            always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
                if (!wrap_rst_n_reg) begin
                    scan_reg  <= '0;
                    seed_reg  <= '0;
                    mask_reg  <= '0;
                    setup_reg <= '0;
                    mode_reg  <= '0;
                end else if (ch_upd) begin
                    if (op_reg == wrapper_pkg::OP_SCAN_TX) begin
                        scan_reg <= sr_reg[LSC-1:0];
                    end
                    if (op_reg == wrapper_pkg::OP_DATA_SIG) begin
                        seed_reg <= sr_reg[LDS-1:0];
                    end
                    if (op_reg == wrapper_pkg::OP_SIG_MASK) begin
                        mask_reg <= sr_reg[LMK-1:0];
                    end
                    if (op_reg == wrapper_pkg::OP_SIG_SETUP) begin
                        setup_reg <= sr_reg[LST-1:0];
                    end
                    if (op_reg == wrapper_pkg::OP_MODE_REG) begin
                        mode_reg <= sr_reg[LMD-1:0];
                    end
                end
            end

            always_ff @(posedge mclk or negedge wrap_rst_n_reg) begin
                if (!wrap_rst_n_reg) begin
                    seed_ld_reg <= 1'b0;
                    mode_wr_reg <= 1'b0;
                    wso_reg     <= 1'b0;
                end else begin
                    seed_ld_reg <= ch_upd & (op_reg == wrapper_pkg::OP_DATA_SIG);
                    mode_wr_reg <= ch_upd & (op_reg == wrapper_pkg::OP_MODE_REG);
                    wso_reg     <= sel_s ? wir_sr_reg[0] : sr_reg[0];
                end
            end

            assign wso[c]                      = wso_reg;
            assign scan_pin_out[c*LSC +: LSC]  = scan_reg;
            assign scan_pin_oe[c]              = (op_reg == wrapper_pkg::OP_SCAN_TX);
            assign scan_pin_float[c]           = (op_reg == wrapper_pkg::OP_SCAN_RX);
            assign tx_all_high[c]              = (op_reg == wrapper_pkg::OP_TX_HIGH);
            assign dsig_seed[c*LDS +: LDS]     = seed_reg;
            assign dsig_seed_load[c]           = seed_ld_reg;
            assign sig_mask[c*LMK +: LMK]      = mask_reg;
            assign csig_setup[c*LST +: LST]    = setup_reg;
            assign mode_reg_out[c*LMD +: LMD]  = mode_reg;
            assign mode_reg_wr[c]              = mode_wr_reg;
        end
    endgenerate

endmodule : test_wrapper_regs

// file: rtl/wrapper_pkg.sv
package wrapper_pkg;

    // ************************************************************
    // Instruction register layout
    // ************************************************************
    localparam int           MAX_CH     = 8;
    localparam int           WIR_W      = 12;
    localparam int           CH_MSB     = 11;
    localparam int           CH_LSB     = 8;
    localparam int           OP_MSB     = 7;
    localparam logic [11:0]  WIR_RESET  = 12'h000;
    localparam logic [3:0]   CH_ALL     = 4'hF;
    localparam int           SYNC_W     = 6;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_BYPASS      = 8'h00;
    localparam logic [7:0] OP_SCAN_RX     = 8'h01;
    localparam logic [7:0] OP_SCAN_TX     = 8'h02;
    localparam logic [7:0] OP_FUNC_RESET  = 8'h05;
    localparam logic [7:0] OP_DATA_SIG    = 8'h09;
    localparam logic [7:0] OP_CMD_SIG     = 8'h0A;
    localparam logic [7:0] OP_TX_HIGH     = 8'h0B;
    localparam logic [7:0] OP_SIG_MASK    = 8'h0C;
    localparam logic [7:0] OP_SIG_SETUP   = 8'h0D;
    localparam logic [7:0] OP_TEMP        = 8'h0F;
    localparam logic [7:0] OP_MODE_REG    = 8'h10;
    localparam logic [7:0] OP_ERR_STICKY  = 8'h11;

    // ************************************************************
    // Data register lengths
    // ************************************************************
    localparam int LEN_W      = 9;
    localparam int SR_W       = 320;
    localparam int LEN_BYPASS = 1;
    localparam int LEN_SCAN   = 215;
    localparam int LEN_DSIG   = 320;
    localparam int LEN_CSIG   = 30;
    localparam int LEN_MASK   = 72;
    localparam int LEN_SETUP  = 8;
    localparam int LEN_TEMP   = 8;
    localparam int LEN_MODE   = 128;
    localparam int LEN_STICKY = 175;

    function automatic logic op_known(input logic [7:0] op);
        case (op)
            OP_BYPASS, OP_SCAN_RX, OP_SCAN_TX, OP_FUNC_RESET, OP_DATA_SIG, OP_CMD_SIG, OP_TX_HIGH,
            OP_SIG_MASK, OP_SIG_SETUP, OP_TEMP, OP_MODE_REG, OP_ERR_STICKY: op_known = 1'b1;
            default: op_known = 1'b0;
        endcase
    endfunction : op_known

    function automatic logic [8:0] op_len(input logic [7:0] op);
        case (op)
            OP_SCAN_RX, OP_SCAN_TX: op_len = 9'(LEN_SCAN);
            OP_DATA_SIG:            op_len = 9'(LEN_DSIG);
            OP_CMD_SIG:             op_len = 9'(LEN_CSIG);
            OP_SIG_MASK:            op_len = 9'(LEN_MASK);
            OP_SIG_SETUP:           op_len = 9'(LEN_SETUP);
            OP_TEMP:                op_len = 9'(LEN_TEMP);
            OP_MODE_REG:            op_len = 9'(LEN_MODE);
            OP_ERR_STICKY:          op_len = 9'(LEN_STICKY);
            default:                op_len = 9'(LEN_BYPASS);
        endcase
    endfunction : op_len

endpackage : wrapper_pkg

// file: tb/test_host_model.sv
`timescale 1ns/1ps
module test_host_model (
    input  wire logic       mclk,       // System clock
    input  wire logic [7:0] wso,        // Serial outputs
    output logic            wrck,       // Test clock
    output logic            wsi,        // Serial data
    output logic            select_wir, // Instruction select
    output logic            capture_wr, // Capture strobe
    output logic            shift_wr,   // Shift strobe
    output logic            update_wr   // Update strobe
);
    // ********************
    // Serial port driver
    // ********************
    initial {wrck, wsi, select_wir, capture_wr, shift_wr, update_wr} = '0;
    // One 360 ns period; the clock rests low between frames
    task automatic cyc(input logic c, s, u, d, output logic [7:0] w);
        @(posedge mclk);
        {capture_wr, shift_wr, update_wr} <= {c, s, u};
        wsi <= d;
        repeat (4) @(posedge mclk);
        w = wso;
        wrck <= 1'b1;
        repeat (4) @(posedge mclk);
        wrck <= 1'b0;
    endtask : cyc
    // Select moves alone, on an idle period
    task automatic sel(input logic v);
        logic [7:0] w;
        @(posedge mclk);
        select_wir <= v;
        cyc(1'b0, 1'b0, 1'b0, ~wsi, w);
    endtask : sel
    task automatic ir(input logic [11:0] v);
        logic [7:0] w;
        sel(1'b1);
        for (int i = 0; i < 12; i++) cyc(1'b0, 1'b1, 1'b0, v[i], w);
        cyc(1'b0, 1'b0, 1'b1, ~wsi, w);
        sel(1'b0);
    endtask : ir
    task automatic dr(input int n, ch, input logic [319:0] din, output logic [319:0] got);
        logic [7:0] w;
        got = '0;
        cyc(1'b1, 1'b0, 1'b0, ~wsi, w);
        for (int i = 0; i < n; i++) begin
            cyc(1'b0, 1'b1, 1'b0, din[i], w);
            got[i] = w[ch];
        end
        cyc(1'b0, 1'b0, 1'b1, ~wsi, w);
    endtask : dr
endmodule : test_host_model

// file: tb/test_wrapper_regs_chk.sv
`timescale 1ns/1ps
module test_wrapper_regs_chk #(
    parameter int NUM_CH = 8
) (
    input wire logic                                mclk,           // System clock
    input wire logic                                resetn,         // Block reset
    input wire logic                                wrck,           // Test clock pin
    input wire logic                                wrst_n,         // Wrapper reset
    input wire logic [NUM_CH-1:0]                   scan_pin_oe,    // Scan drives pins
    input wire logic [NUM_CH-1:0]                   scan_pin_float, // Pins float
    input wire logic [NUM_CH-1:0]                   tx_all_high,    // Transmit high
    input wire logic [NUM_CH*wrapper_pkg::LEN_SCAN-1:0] scan_pin_out, // Scan drive values
    input wire logic [NUM_CH*wrapper_pkg::LEN_MASK-1:0] sig_mask,     // Signature mask
    input wire logic [NUM_CH-1:0]                   mode_reg_wr,    // Mode write pulse
    input wire logic                                func_reset,     // Functional reset pulse
    input wire logic                                self_test_kill  // Self-test stop
);
    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_gone(logic v);
        !v;
    endsequence
    a_kill_in_reset: assert property (!wrst_n |-> self_test_kill)
        else $error("self test not stopped in wrapper reset");
    a_reset_bypass: assert property (!wrst_n |-> (scan_pin_oe | scan_pin_float | tx_all_high) == '0)
        else $error("test mode left on in wrapper reset");
    a_mask_cleared: assert property (!wrst_n |-> sig_mask == '0)
        else $error("signature mask not cleared");
    a_rx_tx_apart: assert property (|scan_pin_oe |-> (scan_pin_oe & scan_pin_float) == '0)
        else $error("channel both floating and driving");
    // Update acts on the falling test clock, so pin modes only move while it is low or in wrapper reset
    a_oe_on_fall: assert property ($changed(scan_pin_oe) |-> !wrck || !wrst_n)
        else $error("drive enable changed while test clock high");
    a_float_on_fall: assert property ($changed(scan_pin_float) |-> !wrck || !wrst_n)
        else $error("float changed while test clock high");
    a_out_on_fall: assert property ($changed(scan_pin_out) |-> !wrck || !wrst_n)
        else $error("scan drive changed while test clock high");
    a_func_one_shot: assert property (func_reset |-> ##1 s_gone(func_reset))
        else $error("functional reset longer than one cycle");
    a_mode_pulse: assert property (|mode_reg_wr |-> ##1 s_gone(|mode_reg_wr))
        else $error("mode write longer than one cycle");
endmodule : test_wrapper_regs_chk
bind test_wrapper_regs test_wrapper_regs_chk #(.NUM_CH(NUM_CH)) test_wrapper_regs_chk_i (
    .mclk(mclk), .resetn(resetn), .wrck(wrck), .wrst_n(wrst_n), .scan_pin_oe(scan_pin_oe),
    .scan_pin_float(scan_pin_float), .tx_all_high(tx_all_high), .scan_pin_out(scan_pin_out),
    .sig_mask(sig_mask), .mode_reg_wr(mode_reg_wr), .func_reset(func_reset), .self_test_kill(self_test_kill));

// file: tb/test_wrapper_regs_tb_top.sv
`timescale 1ns/1ps
module test_wrapper_regs_tb_top;
    // ********************
    // Bench
    // ********************
    logic          mclk = 0, resetn = 0, wrst_n = 0;
    logic          wrck, wsi, select_wir, capture_wr, shift_wr, update_wr, func_reset, self_test_kill;
    logic [7:0]    wso, scan_pin_oe, scan_pin_float, tx_all_high, mode_reg_wr, temp_code = '0;
    logic [1719:0] scan_pin_in = '0, scan_pin_out;
    logic [1023:0] mode_reg_in = '0, mode_reg_out;
    logic [319:0]  din, got;
    logic [2559:0] dsig_in, dsig_seed;
    logic [239:0]  csig_in;
    logic [1399:0] sticky_in;
    logic [575:0]  sig_mask;
    logic [63:0]   csig_setup;
    logic [7:0]    dsig_seed_load;
    int            num_errors = 0, n_compared = 0, cycles = 0, resets = 0;
    always #20 mclk = ~mclk;
    test_host_model test_host_model_i (.mclk(mclk), .wso(wso), .wrck(wrck), .wsi(wsi), .select_wir(select_wir),
        .capture_wr(capture_wr), .shift_wr(shift_wr), .update_wr(update_wr));
    test_wrapper_regs #(.NUM_CH(8)) test_wrapper_regs_i (.mclk(mclk), .resetn(resetn), .wrck(wrck),
        .wrst_n(wrst_n), .wsi(wsi), .select_wir(select_wir), .capture_wr(capture_wr), .shift_wr(shift_wr),
        .update_wr(update_wr), .wso(wso), .scan_pin_in(scan_pin_in), .scan_pin_out(scan_pin_out),
        .scan_pin_oe(scan_pin_oe), .scan_pin_float(scan_pin_float), .tx_all_high(tx_all_high),
        .dsig_in(dsig_in), .dsig_seed(dsig_seed), .dsig_seed_load(dsig_seed_load), .csig_in(csig_in),
        .sig_mask(sig_mask), .csig_setup(csig_setup), .temp_code(temp_code),
        .mode_reg_in(mode_reg_in), .mode_reg_out(mode_reg_out), .mode_reg_wr(mode_reg_wr), .sticky_in(sticky_in),
        .func_reset(func_reset), .self_test_kill(self_test_kill));
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [319:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One-bit path: each bit reappears one shift later
    task automatic byp(input int ch);
        din = 320'($urandom);
        test_host_model_i.dr(8, ch, din, got);
        chk("bypass", 320'(din[6:0]), 320'(got[7:1]));
    endtask : byp
    always @(posedge mclk) begin
        resets += int'(func_reset === 1'b1);
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(41171));
        foreach (scan_pin_in[i]) scan_pin_in[i] <= 1'($urandom);
        foreach (mode_reg_in[i]) mode_reg_in[i] <= 1'($urandom);
        foreach (dsig_in[i]) dsig_in[i] <= 1'($urandom);
        foreach (csig_in[i]) csig_in[i] <= 1'($urandom);
        foreach (sticky_in[i]) sticky_in[i] <= 1'($urandom);
        temp_code <= 8'($urandom);
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        wrst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int c = 0; c < 8; c++) byp(c);
        test_host_model_i.ir(12'h201);
        repeat (6) @(posedge mclk);
        chk("float", 8'h04, scan_pin_float);
        test_host_model_i.dr(215, 2, din, got);
        chk("rx_capture", scan_pin_in[430+:215], got[214:0]);
        for (int i = 0; i < 10; i++) din[i*32+:32] = $urandom;
        test_host_model_i.ir(12'hF02);
        test_host_model_i.dr(215, 5, din, got);
        repeat (6) @(posedge mclk);
        chk("tx_oe", 8'hFF, scan_pin_oe);
        for (int c = 0; c < 8; c++) chk("tx_drive", din[214:0], scan_pin_out[c*215+:215]);
        test_host_model_i.ir(12'h901);
        repeat (6) @(posedge mclk);
        chk("reserved", 16'hFF00, {scan_pin_oe, scan_pin_float});
        test_host_model_i.ir(12'h80F);
        test_host_model_i.dr(8, 0, din, got);
        chk("temp", temp_code, got[7:0]);
        test_host_model_i.ir(12'hF14);
        byp(3);
        chk("unknown_oe", 8'h00, scan_pin_oe);
        test_host_model_i.ir(12'h610);
        test_host_model_i.dr(128, 6, din, got);
        repeat (6) @(posedge mclk);
        chk("mode_read", mode_reg_in[768+:128], got[127:0]);
        chk("mode_write", din[127:0], mode_reg_out[768+:128]);
        test_host_model_i.ir(12'h311);
        test_host_model_i.dr(175, 3, din, got);
        chk("sticky", sticky_in[525+:175], got[174:0]);
        test_host_model_i.ir(12'h40A);
        test_host_model_i.dr(30, 4, din, got);
        chk("csig", csig_in[120+:30], got[29:0]);
        test_host_model_i.ir(12'h109);
        test_host_model_i.dr(320, 1, din, got);
        repeat (6) @(posedge mclk);
        chk("dsig", dsig_in[320+:320], got);
        chk("seed", din, dsig_seed[320+:320]);
        test_host_model_i.ir(12'hF0C);
        test_host_model_i.dr(72, 0, din, got);
        repeat (6) @(posedge mclk);
        chk("mask", din[71:0], sig_mask[504+:72]);
        test_host_model_i.ir(12'h70D);
        test_host_model_i.dr(8, 7, din, got);
        repeat (6) @(posedge mclk);
        chk("setup", din[7:0], csig_setup[56+:8]);
        test_host_model_i.ir(12'h50B);
        repeat (6) @(posedge mclk);
        chk("tx_high", 8'h20, tx_all_high);
        test_host_model_i.ir(12'hF05);
        repeat (6) @(posedge mclk);
        chk("func_reset", 1, resets);
        test_host_model_i.ir(12'h102);
        wrst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("wrapper_reset", 9'h100, {self_test_kill, scan_pin_oe});
        chk("mask_reset", 0, {sig_mask, csig_setup});
        wrst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        byp(1);
        print_verdict();
    end
endmodule : test_wrapper_regs_tb_top
